// file: design/adc_lpm_params.svh
`ifndef ADC_LPM_PARAMS_SVH
`define ADC_LPM_PARAMS_SVH

// Register byte addresses on the AXI4-Lite slave.
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_MASK          8'h08
`define REG_RESULT        8'h0c
`define REG_STATE         8'h10

// Control register fields.
`define CTRL_ENABLE       0
`define CTRL_CONTINUOUS   1
`define CTRL_SW_START     2
`define CTRL_ASYNC_SEL    3
`define CTRL_IRQ_ENABLE   4
`define CTRL_HW_TRIG_EN   5
`define CTRL_WIDTH        6
`define CTRL_RW_MASK      6'h3b

// Status and mask register fields.
`define STAT_COMPLETE     0
`define STAT_ABORTED      1
`define STAT_WIDTH        2

// Result layout: low byte and high nibble.
`define RESULT_LOW_W      8
`define RESULT_HIGH_W     4

// Reset values.
`define CTRL_RESET        6'h00
`define STATUS_RESET      2'h0
`define MASK_RESET        2'h0
`define RESULT_LOW_RESET  8'h00
`define RESULT_HIGH_RESET 4'h0

// AXI response codes.
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// Default conversion timing in conversion clock ticks and bus clock divide.
`define CONV_TICKS_DEF    20
`define BUS_DIV_DEF       2

`endif

// file: design/adc_lpm_pkg.sv
package adc_lpm_pkg;

	typedef enum logic [1:0] {
		MODE_RUN        = 2'b00,
		MODE_WAIT       = 2'b01,
		MODE_LIGHT_STOP = 2'b10,
		MODE_DEEP_STOP  = 2'b11
	} power_mode_type;

	typedef enum logic [0:0] {
		CONV_IDLE    = 1'b0,
		CONV_RUNNING = 1'b1
	} conv_state_type;

endpackage

// file: design/three_stage_sync.sv
`timescale 1ns/100ps

// Brings pin-level signals into core_clk; a new level is accepted only once
// the second and third stages agree, which also rejects one-cycle glitches.
module three_stage_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] stage3;
		logic [WIDTH-1:0] level;
		logic [WIDTH-1:0] rise;
	} sync_state_type;

	sync_state_type sync_q;
	sync_state_type sync_d;

	always_comb begin
		sync_d        = sync_q;
		sync_d.stage1 = async_in;
		sync_d.stage2 = sync_q.stage1;
		sync_d.stage3 = sync_q.stage2;
		for (int i = 0; i < WIDTH; i++) begin
			if (sync_q.stage2[i] == sync_q.stage3[i]) begin
				sync_d.level[i] = sync_q.stage2[i];
			end
			sync_d.rise[i] = (sync_q.stage2[i] == sync_q.stage3[i]) &&
				sync_q.stage2[i] && !sync_q.level[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync_q <= '0;
		end else begin
			sync_q <= sync_d;
		end
	end

	assign level = sync_q.level;
	assign rise  = sync_q.rise;

endmodule

// file: design/adc_low_power_mode_control.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "adc_lpm_params.svh"

module adc_low_power_mode_control #(
	parameter int CONV_TICKS = `CONV_TICKS_DEF,
	parameter int BUS_DIV    = `BUS_DIV_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	input  wire logic [1:0]  power_mode,
	input  wire logic        hw_trigger,
	input  wire logic        async_conversion_clock,
	input  wire logic [11:0] analog_sample,
	output logic             sample_hold,
	output logic             irq,
	output logic             wake_req
);

	localparam int CNT_W = $clog2(CONV_TICKS + 1);
	localparam int DIV_W = $clog2(BUS_DIV + 1);
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TICKS - 1);
	localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(BUS_DIV - 1);

	typedef struct packed {
		logic                          aw_got;
		logic [7:0]                    awaddr;
		logic                          w_got;
		logic [31:0]                   wdata;
		logic [3:0]                    wstrb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
		logic [`CTRL_WIDTH-1:0]        ctrl;
		logic [`STAT_WIDTH-1:0]        status;
		logic [`STAT_WIDTH-1:0]        mask;
		logic [`RESULT_HIGH_W-1:0]     result_high_reg;
		logic [`RESULT_LOW_W-1:0]      result_low_reg;
		adc_lpm_pkg::conv_state_type   conv_state;
		logic [CNT_W-1:0]              conv_cnt;
		logic [DIV_W-1:0]              div_cnt;
		logic                          cont_armed;
		logic                          irq;
		logic                          wake;
	} state_type;

	state_type q;
	state_type d;

	logic [1:0] pin_level;
	logic [1:0] pin_rise;

	// Bit 0 carries the hardware trigger, bit 1 the asynchronous clock.
	three_stage_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.async_in ({async_conversion_clock, hw_trigger}),
		.level    (pin_level),
		.rise     (pin_rise)
	);

	adc_lpm_pkg::power_mode_type mode;
	logic                        async_sel;
	logic                        clk_live;
	logic                        conv_tick;
	logic                        start_req;
	logic                        wr_ok;
	logic                        rd_ok;
	logic [`STAT_WIDTH-1:0]      stat_set;
	logic [`STAT_WIDTH-1:0]      stat_clr;
	logic [`STAT_WIDTH-1:0]      irq_gate;

	assign mode      = adc_lpm_pkg::power_mode_type'(power_mode);
	assign async_sel = q.ctrl[`CTRL_ASYNC_SEL];

	// The bus-derived conversion clock is stopped in both stop modes, while
	// the asynchronous one keeps ticking through light stop only.
	always_comb begin
		case (mode)
			adc_lpm_pkg::MODE_RUN:        clk_live = 1'b1;
			adc_lpm_pkg::MODE_WAIT:       clk_live = 1'b1;
			adc_lpm_pkg::MODE_LIGHT_STOP: clk_live = async_sel;
			adc_lpm_pkg::MODE_DEEP_STOP:  clk_live = 1'b0;
			default:                      clk_live = 1'b0;
		endcase
	end

	assign conv_tick = clk_live && q.ctrl[`CTRL_ENABLE] &&
		(async_sel ? pin_rise[1] : (q.div_cnt == DIV_LAST));

	always_comb begin
		d         = q;
		stat_set  = '0;
		stat_clr  = '0;
		start_req = 1'b0;
		wr_ok     = 1'b0;
		rd_ok     = 1'b0;

		// Write address and data are latched independently, in either order.
		if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			case (q.awaddr)
				`REG_CTRL: begin
					wr_ok = 1'b1;
					if (q.wstrb[0]) begin
						d.ctrl = q.wdata[`CTRL_WIDTH-1:0] & `CTRL_RW_MASK;
						start_req = q.wdata[`CTRL_SW_START] && q.wdata[`CTRL_ENABLE];
					end
				end
				`REG_STATUS: begin
					wr_ok = 1'b1;
					if (q.wstrb[0]) begin
						stat_clr = q.wdata[`STAT_WIDTH-1:0];
					end
				end
				`REG_MASK: begin
					wr_ok = 1'b1;
					if (q.wstrb[0]) begin
						d.mask = q.wdata[`STAT_WIDTH-1:0];
					end
				end
				`REG_RESULT: wr_ok = 1'b1;
				`REG_STATE:  wr_ok = 1'b1;
				default:     wr_ok = 1'b0;
			endcase
			d.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata  = '0;
			rd_ok    = 1'b1;
			case (s_axi_araddr)
				`REG_CTRL:   d.rdata[`CTRL_WIDTH-1:0] = q.ctrl;
				`REG_STATUS: d.rdata[`STAT_WIDTH-1:0] = q.status;
				`REG_MASK:   d.rdata[`STAT_WIDTH-1:0] = q.mask;
				`REG_RESULT: begin
					d.rdata[`RESULT_LOW_W+`RESULT_HIGH_W-1:0] =
						{q.result_high_reg, q.result_low_reg};
				end
				`REG_STATE: begin
					d.rdata[3:0] = {q.cont_armed, power_mode,
						q.conv_state == adc_lpm_pkg::CONV_RUNNING};
				end
				default: rd_ok = 1'b0;
			endcase
			d.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// Bus clock divider feeding the synchronous conversion clock.
		d.div_cnt = (q.div_cnt == DIV_LAST) ? '0 : DIV_W'(q.div_cnt + 1'b1);

		// The hardware trigger also counts in light stop when the asynchronous
		// clock is chosen; the bus clock is frozen there otherwise.
		if (pin_rise[0] && q.ctrl[`CTRL_HW_TRIG_EN] && clk_live) begin
			start_req = 1'b1;
		end

		case (q.conv_state)
			adc_lpm_pkg::CONV_IDLE: begin
				if (start_req && clk_live && d.ctrl[`CTRL_ENABLE]) begin
					d.conv_state = adc_lpm_pkg::CONV_RUNNING;
					d.conv_cnt   = '0;
					d.cont_armed = 1'b1;
				end
			end
			adc_lpm_pkg::CONV_RUNNING: begin
				if (mode == adc_lpm_pkg::MODE_LIGHT_STOP && !async_sel) begin
					// Abort discards the conversion; results stay as they were.
					d.conv_state = adc_lpm_pkg::CONV_IDLE;
					d.cont_armed = 1'b0;
					stat_set[`STAT_ABORTED] = 1'b1;
				end else if (!q.ctrl[`CTRL_ENABLE]) begin
					d.conv_state = adc_lpm_pkg::CONV_IDLE;
					d.cont_armed = 1'b0;
				end else if (conv_tick) begin
					if (q.conv_cnt == CONV_LAST) begin
						// Completion in run, wait or light stop.
						d.result_low_reg  = analog_sample[`RESULT_LOW_W-1:0];
						d.result_high_reg =
							analog_sample[`RESULT_LOW_W+`RESULT_HIGH_W-1:`RESULT_LOW_W];
						stat_set[`STAT_COMPLETE] = 1'b1;
						d.conv_cnt = '0;
						if (!(q.ctrl[`CTRL_CONTINUOUS] && q.cont_armed)) begin
							d.conv_state = adc_lpm_pkg::CONV_IDLE;
						end
					end else begin
						d.conv_cnt = CNT_W'(q.conv_cnt + 1'b1);
					end
				end
			end
			default: d.conv_state = adc_lpm_pkg::CONV_IDLE;
		endcase

		// Continuous restarts are refused once an abort has disarmed them.
		if (!d.ctrl[`CTRL_CONTINUOUS]) begin
			d.cont_armed = d.conv_state == adc_lpm_pkg::CONV_RUNNING;
		end

		// A hardware event in the same cycle as a software clear survives.
		d.status = (q.status & ~stat_clr) | stat_set;

		// Deep stop powers the converter down and reloads the control, status, mask and result registers
		// and the conversion state, so software finds reset values on exit and must set it up again.
		if (mode == adc_lpm_pkg::MODE_DEEP_STOP) begin
			d.ctrl            = `CTRL_RESET;
			d.status          = `STATUS_RESET;
			d.mask            = `MASK_RESET;
			d.result_low_reg  = `RESULT_LOW_RESET;
			d.result_high_reg = `RESULT_HIGH_RESET;
			d.conv_state      = adc_lpm_pkg::CONV_IDLE;
			d.conv_cnt        = '0;
			d.cont_armed      = 1'b0;
		end

		// The completion source also needs its own interrupt enable.
		irq_gate                 = d.mask;
		irq_gate[`STAT_COMPLETE] = d.mask[`STAT_COMPLETE] && d.ctrl[`CTRL_IRQ_ENABLE];
		d.irq  = |(d.status & irq_gate);
		d.wake = d.irq && (mode == adc_lpm_pkg::MODE_WAIT ||
			mode == adc_lpm_pkg::MODE_LIGHT_STOP);
	end

	// Results only move at completion or on deep stop entry, never on light stop entry or exit.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			q                 <= '0;
			q.ctrl            <= `CTRL_RESET;
			q.status          <= `STATUS_RESET;
			q.mask            <= `MASK_RESET;
			q.result_low_reg  <= `RESULT_LOW_RESET;
			q.result_high_reg <= `RESULT_HIGH_RESET;
			q.conv_state      <= adc_lpm_pkg::CONV_IDLE;
			q.bresp           <= `RESP_OKAY;
			q.rresp           <= `RESP_OKAY;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready  = !q.w_got && !q.bvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign sample_hold   = q.conv_state == adc_lpm_pkg::CONV_RUNNING;
	assign irq           = q.irq;
	assign wake_req      = q.wake;

endmodule

// file: test/adc_lpm_props.sv
`timescale 1ns/100ps
module adc_lpm_props (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  power_mode,
	input wire logic        sample_hold,
	input wire logic        irq,
	input wire logic        wake_req
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed early");
	AST_AR_RDY: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("arready wrong");
	AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid)
		else $error("write answer late");
	AST_W_BLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	AST_DEEP_OFF: assert property (power_mode == 2'h3 ##1 power_mode == 2'h3 |-> !sample_hold && !irq && !wake_req)
		else $error("active in deep stop");
	AST_WAKE_MODE: assert property (wake_req |-> $past(power_mode) inside {2'h1, 2'h2})
		else $error("wake outside wait or light stop");
	AST_WAKE_IRQ: assert property (wake_req |-> irq || $past(irq))
		else $error("wake without interrupt");

	cover property (wake_req);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property ($fell(sample_hold) && power_mode == 2'h2);
endmodule

bind adc_low_power_mode_control adc_lpm_props u_props (
	.core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .power_mode, .sample_hold, .irq, .wake_req
);

// file: test/adc_low_power_mode_control_tb.sv
`timescale 1ns/100ps
module adc_low_power_mode_control_tb;
	logic        core_clk = 1'h0;
	logic        rstn = 1'h0;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_bready = 1'h1;
	logic        s_axi_rready = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  power_mode = 2'h0;
	logic        hw_trigger = 1'h0;
	logic        async_conversion_clock = 1'h0;
	logic        aclk_run = 1'h0;
	logic [11:0] analog_sample = 12'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        sample_hold, irq, wake_req;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
	logic [31:0] s_axi_rdata, rv;
	int          err_total = 0, n_tests = 0, i;

	adc_low_power_mode_control #(.CONV_TICKS(3), .BUS_DIV(2)) DUT (
		.core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.power_mode, .hw_trigger, .async_conversion_clock, .analog_sample, .sample_hold,
		.irq, .wake_req
	);

	always #25 core_clk = ~core_clk;
	// Edges land on falling core edges, two cycles apart, so the synchroniser sees each one.
	always #100 if (aclk_run) async_conversion_clock = ~async_conversion_clock;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
	endtask

	task rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask

	task test_done;
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		test_done;
	end

	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'h1;
		for (i = 0; i < 4; i++) begin
			rd(8'(i * 4));
			chk(rv, 32'h0);
		end
		rd(8'h40);
		chk({30'h0, rr}, 32'h2);
		wr(8'h40, 32'h1);
		chk({30'h0, br}, 32'h2);
		wr(8'h08, 32'h0);
		chk({30'h0, br}, 32'h0);
		power_mode <= 2'h1;
		analog_sample <= 12'h5a3;
		wr(8'h08, 32'h1);
		wr(8'h00, 32'h15);
		while (irq !== 1'h1) @(posedge core_clk);
		chk({31'h0, wake_req}, 32'h1);
		rd(8'h04);
		chk(rv, 32'h1);
		rd(8'h0c);
		chk(rv, 32'h5a3);
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h0);
		rd(8'h04);
		chk(rv, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Abort in mid-conversion; the mask is clear, so the abort must stay silent.
		power_mode <= 2'h0;
		analog_sample <= 12'h0ff;
		wr(8'h00, 32'h15);
		@(posedge core_clk);
		chk({31'h0, sample_hold}, 32'h1);
		power_mode <= 2'h2;
		repeat (3) @(posedge core_clk);
		chk({31'h0, sample_hold}, 32'h0);
		rd(8'h04);
		chk(rv, 32'h2);
		chk({31'h0, irq}, 32'h0);
		rd(8'h0c);
		chk(rv, 32'h5a3);
		power_mode <= 2'h0;
		repeat (20) @(posedge core_clk);
		chk({31'h0, sample_hold}, 32'h0);
		rd(8'h0c);
		chk(rv, 32'h5a3);
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h1);
		wr(8'h00, 32'h39);
		power_mode <= 2'h2;
		analog_sample <= 12'h9c6;
		aclk_run = 1'h1;
		hw_trigger <= 1'h1;
		while (irq !== 1'h1) @(posedge core_clk);
		chk({31'h0, wake_req}, 32'h1);
		rd(8'h0c);
		chk(rv, 32'h9c6);
		aclk_run = 1'h0;
		hw_trigger <= 1'h0;
		power_mode <= 2'h3;
		repeat (4) @(posedge core_clk);
		chk({30'h0, irq, sample_hold}, 32'h0);
		power_mode <= 2'h0;
		for (i = 0; i < 4; i++) begin
			rd(8'(i * 4));
			chk(rv, 32'h0);
		end
		test_done;
	end
endmodule
